// ===== host_bus_width_control.v
// Host bus width control: width selection, write posting, byte splitting and bank strobes
`timescale 1ns/1ps
`include "host_bus_width_control_defs.vh"

module host_bus_width_control #(
  parameter ADDR_W = 18
) (
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite slave
  input  wire [9:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [9:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Host side
  input  wire              bus16_present,
  input  wire              cpu_mem_req,
  input  wire              cpu_mem_write,
  input  wire              cpu_io_req,
  input  wire [ADDR_W-1:0] cpu_addr,
  input  wire [15:0]       cpu_wdata,
  input  wire              high_byte_enable_input_n,
  input  wire              rom_decode_input_n,
  output reg               cpu_ready,
  output reg  [15:0]       cpu_rdata,
  output reg               wide_memory_indication_n,
  output reg               wide_io_indication_n,
  output reg               low_buffer_enable_n,
  output reg               high_buffer_enable_n,
  // Display memory side
  input  wire              pointer_fetch,
  input  wire              refresh_cycle,
  input  wire              row_strobe_req,
  input  wire              shift_clock_req,
  input  wire              transfer_req,
  input  wire [7:0]        mem_rdata,
  output reg  [ADDR_W-1:0] mem_addr,
  output reg  [7:0]        mem_wdata,
  output reg               mem_we,
  output reg               mem_cycle,
  output reg  [1:0]        pointer_addr_hi,
  output reg               extra_row_address,
  output reg               row_strobe_bank_zero_n,
  output reg               row_strobe_bank_one_n,
  output reg               row_strobe_bank_two_n,
  output reg               row_strobe_bank_three_n,
  output reg               serial_out_enable_bank_zero_n,
  output reg               serial_out_enable_bank_one_n,
  output reg               serial_out_enable_bank_two_n,
  output reg               serial_out_enable_bank_three_n,
  output reg  [3:0]        shift_clock_bank_n,
  output reg               transfer_output_enable_n
);

  localparam ST_IDLE   = 2'h0;
  localparam ST_LOW    = 2'h1;
  localparam ST_HIGH   = 2'h2;
  localparam ST_FINISH = 2'h3;

  // One-hot low-active bank decode, shared by strobe and serial enables
  function [3:0] bank_onehot_n;
    input [1:0] sel;
    begin
      bank_onehot_n = ~(4'h1 << sel);
    end
  endfunction

  reg  [4:0]        ctrl_q;
  reg  [1:0]        ptr_bank_q;
  reg               unlocked_q;
  reg  [1:0]        bank_select_q;
  reg  [9:0]        aw_addr_q;
  reg  [7:0]        w_data_q;
  reg               aw_have_q;
  reg               w_have_q;
  reg  [1:0]        state_q;
  reg               second_q;
  reg               posted_q;
  reg               wide_q;
  reg               is_write_q;
  reg  [ADDR_W-1:0] acc_addr_q;
  reg  [15:0]       acc_data_q;
  reg  [3:0]        cnt_q;
  reg               cpu_busy_q;

  wire bank_en   = ctrl_q[`BIT_BANK_ENABLE];
  wire rom16_en  = ctrl_q[`BIT_ROM16_ENABLE];
  wire fast_wr   = ctrl_q[`BIT_FAST_WRITE];
  wire io16_en   = ctrl_q[`BIT_IO16_ENABLE];
  wire wide_memory_indication_en  = ctrl_q[`BIT_WIDE_MEMORY_INDICATION_ENABLE];
  wire rom_hit   = ~rom_decode_input_n;
  wire wr_fire   = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [7:0] status_byte = {bus16_present, ptr_bank_q, ctrl_q};
  wire new_req   = cpu_mem_req & ~cpu_busy_q & (state_q == ST_IDLE);
  wire wide_req  = wide_memory_indication_en & ~high_byte_enable_input_n & ~cpu_addr[0];
  wire cnt_done  = (cnt_q == 4'h0);

  // AXI write address/data capture, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 10'h000;
      w_data_q      <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_q)
          `OFF_UNLOCK, `OFF_BANK_SELECT, `OFF_BUS_WIDTH_CTRL: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; control bits move only while unlocked
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q        <= `CTRL_RESET;
      ptr_bank_q    <= `PTR_BANK_RESET;
      unlocked_q    <= 1'b0;
      bank_select_q <= `BANK_SELECT_RESET;
    end else if (wr_fire) begin
      case (aw_addr_q)
        `OFF_UNLOCK: unlocked_q <= (w_data_q == `UNLOCK_VALUE);
        `OFF_BANK_SELECT: bank_select_q <= w_data_q[1:0];
        `OFF_BUS_WIDTH_CTRL: begin
          if (unlocked_q) begin
            ctrl_q     <= w_data_q[4:0];
            ptr_bank_q <= w_data_q[6:5];
          end
        end
        default: ;
      endcase
    end
  end

  // AXI read channel; locked control register reads as zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFF_UNLOCK: s_axi_rdata <= {31'h00000000, unlocked_q};
          `OFF_BANK_SELECT: s_axi_rdata <= {30'h00000000, bank_select_q};
          `OFF_BUS_WIDTH_CTRL: s_axi_rdata <= unlocked_q ? {24'h000000, status_byte} : 32'h00000000;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Host width indications and ROM buffer enables, registered for clean pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      wide_memory_indication_n <= 1'b1;
      wide_io_indication_n     <= 1'b1;
      low_buffer_enable_n      <= 1'b1;
      high_buffer_enable_n     <= 1'b1;
    end else begin
      wide_io_indication_n     <= ~(io16_en & cpu_io_req);
      wide_memory_indication_n <= ~((wide_memory_indication_en & cpu_mem_req) | (rom16_en & rom_hit));
      if (rom_hit & rom16_en) begin
        low_buffer_enable_n  <= cpu_addr[0];
        high_buffer_enable_n <= high_byte_enable_input_n;
      end else if (rom_hit) begin
        low_buffer_enable_n  <= 1'b0;
        high_buffer_enable_n <= 1'b1;
      end else begin
        low_buffer_enable_n  <= 1'b1;
        high_buffer_enable_n <= 1'b1;
      end
    end
  end

  // Access sequencer: one or two byte cycles, posted writes release CPU early
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ST_IDLE;
      second_q   <= 1'b0;
      posted_q   <= 1'b0;
      wide_q     <= 1'b0;
      is_write_q <= 1'b0;
      acc_addr_q <= {ADDR_W{1'b0}};
      acc_data_q <= 16'h0000;
      cnt_q      <= 4'h0;
      cpu_busy_q <= 1'b0;
      cpu_ready  <= 1'b1;
      cpu_rdata  <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (!cpu_mem_req) begin
            cpu_busy_q <= 1'b0;
            cpu_ready  <= 1'b1;
          end
          if (new_req) begin
            acc_addr_q <= cpu_addr;
            acc_data_q <= cpu_wdata;
            is_write_q <= cpu_mem_write;
            wide_q     <= wide_req;
            second_q   <= 1'b0;
            cnt_q      <= `MEM_ACCESS_CYCLES;
            state_q    <= ST_LOW;
            cpu_busy_q <= 1'b1;
            posted_q   <= cpu_mem_write & fast_wr;
            cpu_ready  <= cpu_mem_write & fast_wr;
          end
        end
        ST_LOW, ST_HIGH: begin
          // Posted write pending: a new CPU access is waited
          if (posted_q & cpu_mem_req & ~cpu_busy_q)
            cpu_ready <= 1'b0;
          else if (posted_q & ~cpu_mem_req)
            cpu_busy_q <= 1'b0;
          if (cnt_done) begin
            if (!is_write_q) begin
              if (second_q)
                cpu_rdata[15:8] <= mem_rdata;
              else
                cpu_rdata[7:0] <= mem_rdata;
            end
            if (wide_q & ~second_q) begin
              second_q <= 1'b1;
              cnt_q    <= `MEM_ACCESS_CYCLES;
              state_q  <= ST_HIGH;
            end else begin
              state_q <= ST_FINISH;
            end
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_FINISH: begin
          posted_q <= 1'b0;
          state_q  <= ST_IDLE;
          if (!posted_q)
            cpu_ready <= 1'b1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Internal 8-bit memory port
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_addr  <= {ADDR_W{1'b0}};
      mem_wdata <= 8'h00;
      mem_we    <= 1'b0;
      mem_cycle <= 1'b0;
    end else begin
      mem_cycle <= (state_q == ST_LOW) | (state_q == ST_HIGH);
      mem_we    <= is_write_q & ((state_q == ST_LOW) | (state_q == ST_HIGH));
      mem_addr  <= acc_addr_q | {{(ADDR_W-1){1'b0}}, second_q};
      mem_wdata <= second_q ? acc_data_q[15:8] : acc_data_q[7:0];
    end
  end

  // Pointer address bits, bank strobes and video RAM controls
  always @(posedge aclk) begin
    if (!aresetn) begin
      pointer_addr_hi                <= 2'h0;
      extra_row_address              <= 1'b0;
      {row_strobe_bank_three_n, row_strobe_bank_two_n,
       row_strobe_bank_one_n, row_strobe_bank_zero_n} <= 4'hf;
      {serial_out_enable_bank_three_n, serial_out_enable_bank_two_n,
       serial_out_enable_bank_one_n, serial_out_enable_bank_zero_n} <= 4'hf;
      shift_clock_bank_n             <= 4'hf;
      transfer_output_enable_n       <= 1'b1;
    end else begin
      pointer_addr_hi   <= pointer_fetch ? ptr_bank_q : 2'h0;
      // Extra row line only meaningful for large DRAMs, so silent when banked
      extra_row_address <= ~bank_en & pointer_fetch & ptr_bank_q[1];
      if (!row_strobe_req)
        {row_strobe_bank_three_n, row_strobe_bank_two_n,
         row_strobe_bank_one_n, row_strobe_bank_zero_n} <= 4'hf;
      else if (!bank_en | refresh_cycle)
        {row_strobe_bank_three_n, row_strobe_bank_two_n,
         row_strobe_bank_one_n, row_strobe_bank_zero_n} <= 4'h0;
      else
        {row_strobe_bank_three_n, row_strobe_bank_two_n,
         row_strobe_bank_one_n, row_strobe_bank_zero_n} <=
          bank_onehot_n(pointer_fetch ? ptr_bank_q : bank_select_q);
      if (bank_en) begin
        {serial_out_enable_bank_three_n, serial_out_enable_bank_two_n,
         serial_out_enable_bank_one_n, serial_out_enable_bank_zero_n} <= bank_onehot_n(bank_select_q);
        shift_clock_bank_n <= shift_clock_req ? bank_onehot_n(bank_select_q) : 4'hf;
      end else begin
        {serial_out_enable_bank_three_n, serial_out_enable_bank_two_n,
         serial_out_enable_bank_one_n, serial_out_enable_bank_zero_n} <= 4'h0;
        shift_clock_bank_n <= shift_clock_req ? 4'h0 : 4'hf;
      end
      transfer_output_enable_n <= ~transfer_req;
    end
  end

endmodule // host_bus_width_control

// ===== host_bus_width_control_defs.vh
// Register offsets, field positions, reset values and timing counts for the host bus width control
`ifndef HOST_BUS_WIDTH_CONTROL_DEFS_VH
`define HOST_BUS_WIDTH_CONTROL_DEFS_VH
// Control register index; its byte address is four times the index
`define IDX_BUS_WIDTH_CTRL   8'hff
// AXI4-Lite byte addresses
`define OFF_BUS_WIDTH_CTRL   10'h3fc
`define OFF_UNLOCK           10'h000
`define OFF_BANK_SELECT      10'h004
`define UNLOCK_VALUE         8'hea
// Control register field positions
`define BIT_BUS16_STATUS     7
`define BIT_PTR_BANK_HI      6
`define BIT_PTR_BANK_LO      5
`define BIT_BANK_ENABLE      4
`define BIT_ROM16_ENABLE     3
`define BIT_FAST_WRITE       2
`define BIT_IO16_ENABLE      1
`define BIT_WIDE_MEMORY_INDICATION_ENABLE     0
// Reset values
`define CTRL_RESET           5'h00
`define PTR_BANK_RESET       2'h0
`define BANK_SELECT_RESET    2'h0
// Count loaded for one internal display-memory byte access, which occupies one cycle more
`define MEM_ACCESS_CYCLES    4'h3
// AXI response codes
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

// ===== host_bus_width_control_assertions.sv
// Concurrent checks on the host bus width control ports
`timescale 1ns/1ps
module host_bus_width_control_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        cpu_io_req,
  input wire logic        wide_io_indication_n,
  input wire logic        rom_decode_input_n,
  input wire logic        low_buffer_enable_n,
  input wire logic        high_buffer_enable_n,
  input wire logic        row_strobe_req,
  input wire logic        refresh_cycle,
  input wire logic        pointer_fetch,
  input wire logic        row_strobe_bank_zero_n,
  input wire logic        row_strobe_bank_one_n,
  input wire logic        row_strobe_bank_two_n,
  input wire logic        row_strobe_bank_three_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write answer comes a bounded time after the address is taken
  sequence wr_done;
    ##[1:8] s_axi_bvalid;
  endsequence
  // Decode held two cycles, long enough for the registered enables
  sequence rom_held;
    !rom_decode_input_n [*2];
  endsequence
  a_aw_taken_cause: assert property (s_axi_awready |-> $past(s_axi_awvalid))
    else $error("awready without awvalid");
  a_ar_taken_cause: assert property (s_axi_arready |-> $past(s_axi_arvalid))
    else $error("arready without arvalid");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> wr_done)
    else $error("no write response");
  a_rom_enables: assert property (rom_held |-> !low_buffer_enable_n || !high_buffer_enable_n)
    else $error("rom decode without buffer enable");
  a_io_wide_cause: assert property (!wide_io_indication_n |-> $past(cpu_io_req))
    else $error("wide io indication without io request");
  a_strobe_cause: assert property (!(&{row_strobe_bank_three_n, row_strobe_bank_two_n, row_strobe_bank_one_n,
    row_strobe_bank_zero_n}) |-> $past(row_strobe_req || refresh_cycle || pointer_fetch))
    else $error("row strobe without request");
endmodule // host_bus_width_control_assertions

bind host_bus_width_control host_bus_width_control_assertions u_chk (.*);

// ===== host_mem_model.sv
// Byte-wide display memory behind the internal port
`timescale 1ns/1ps
module host_mem_model (
  input wire logic        aclk,
  input wire logic [17:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_we,
  input wire logic        mem_cycle,
  output logic [7:0]      mem_rdata
);
  logic [7:0] mem_q [0:255];
  logic [7:0] idle_q = 8'h00;
  // Known fill so a wide read shows both bytes
  initial for (int i = 0; i < 256; i++) mem_q[i] = 8'hff ^ 8'(i);
  // Idle data walks so stale bytes are never mistaken for a read
  always @(posedge aclk) begin
    idle_q <= idle_q + 8'h35;
    if (mem_cycle && mem_we) mem_q[mem_addr[7:0]] <= mem_wdata;
  end
  assign mem_rdata = mem_cycle ? mem_q[mem_addr[7:0]] : idle_q;
endmodule // host_mem_model

// ===== test_host_bus_width_control.sv
// Self-checking bench for the host bus width control
`timescale 1ns/1ps
`include "host_bus_width_control_defs.vh"
module test_host_bus_width_control;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bus16_present, cpu_mem_req, cpu_mem_write;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [7:0]  mem_rdata, mem_wdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, shift_clock_bank_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pointer_addr_hi;
  logic [17:0] cpu_addr, mem_addr;
  logic [15:0] cpu_wdata, cpu_rdata;
  logic cpu_io_req, cpu_ready, high_byte_enable_input_n, rom_decode_input_n, wide_memory_indication_n;
  logic wide_io_indication_n, low_buffer_enable_n, high_buffer_enable_n, pointer_fetch, refresh_cycle;
  logic row_strobe_req, shift_clock_req, transfer_req, mem_we, mem_cycle, extra_row_address;
  logic row_strobe_bank_zero_n, row_strobe_bank_one_n, row_strobe_bank_two_n, row_strobe_bank_three_n;
  logic serial_out_enable_bank_zero_n, serial_out_enable_bank_one_n, serial_out_enable_bank_two_n;
  logic serial_out_enable_bank_three_n, transfer_output_enable_n;
  wire [3:0] rows = {row_strobe_bank_three_n, row_strobe_bank_two_n, row_strobe_bank_one_n, row_strobe_bank_zero_n};
  wire [3:0] soes = {serial_out_enable_bank_three_n, serial_out_enable_bank_two_n, serial_out_enable_bank_one_n,
                     serial_out_enable_bank_zero_n};
  int n_fail, samples_checked;
  host_bus_width_control u_host_bus_width_control (.*);
  host_mem_model u_host_mem_model (.*);
  // 25 MHz clock
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hung;
    n_fail++;
    end_of_test;
  endtask
  // Address and data offered together, bready held until the answer
  task automatic wr(logic [9:0] a, logic [7:0] d, logic [1:0] er = `RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (++n > 50) hung();
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(logic [9:0] a, logic [31:0] ed, logic [1:0] er = `RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (++n > 50) hung();
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    check("rdata", s_axi_rdata, ed);
    check("rresp", s_axi_rresp, er);
  endtask
  // One CPU display-memory access; returns edges until released
  task automatic cpu(logic w, logic [17:0] a, logic [15:0] d, output int c);
    c = 0;
    @(posedge aclk);
    cpu_mem_req <= 1'h1;
    cpu_mem_write <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    // Ready seen at the taking edge is still the idle level, so skip it
    do begin
      @(posedge aclk);
      c++;
      if (c > 60) hung();
    end while (c < 2 || !cpu_ready);
    cpu_mem_req <= 1'h0;
  endtask
  task automatic t_lock;
    rd(`OFF_BUS_WIDTH_CTRL, 32'h0);
    wr(`OFF_BUS_WIDTH_CTRL, 8'h1f);
    wr(`OFF_UNLOCK, `UNLOCK_VALUE);
    rd(`OFF_BUS_WIDTH_CTRL, 32'h80);
    rd(10'h040, 32'h0, `RESP_SLVERR);
    wr(10'h040, 8'h12, `RESP_SLVERR);
  endtask
  task automatic t_ctrl;
    wr(`OFF_BUS_WIDTH_CTRL, 8'hff);
    rd(`OFF_BUS_WIDTH_CTRL, 32'hff);
    bus16_present <= 1'h0;
    rd(`OFF_BUS_WIDTH_CTRL, 32'h7f);
  endtask
  task automatic t_rom;
    wr(`OFF_BUS_WIDTH_CTRL, 8'h00);
    rom_decode_input_n <= 1'h0;
    repeat (3) @(posedge aclk);
    check("rom8 bufs", {low_buffer_enable_n, high_buffer_enable_n}, 2'h1);
    wr(`OFF_BUS_WIDTH_CTRL, 8'h08);
    high_byte_enable_input_n <= 1'h0;
    repeat (3) @(posedge aclk);
    check("rom16 bufs", {wide_memory_indication_n, low_buffer_enable_n, high_buffer_enable_n}, 3'h0);
    rom_decode_input_n <= 1'h1;
    high_byte_enable_input_n <= 1'h1;
  endtask
  task automatic t_io;
    wr(`OFF_BUS_WIDTH_CTRL, 8'h03);
    {cpu_io_req, cpu_mem_req} <= 2'h3;
    repeat (2) @(posedge aclk);
    check("io16", wide_io_indication_n, 1'h0);
    check("wide_memory_indication", wide_memory_indication_n, 1'h0);
    wr(`OFF_BUS_WIDTH_CTRL, 8'h00);
    repeat (2) @(posedge aclk);
    check("io8", wide_io_indication_n, 1'h1);
    check("mem8", wide_memory_indication_n, 1'h1);
    {cpu_io_req, cpu_mem_req} <= 2'h0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic t_bank;
    wr(`OFF_BANK_SELECT, 8'h02);
    wr(`OFF_BUS_WIDTH_CTRL, 8'h30);
    row_strobe_req <= 1'h1;
    repeat (3) @(posedge aclk);
    check("bank rows", rows, 4'hb);
    refresh_cycle <= 1'h1;
    repeat (3) @(posedge aclk);
    check("refresh rows", rows, 4'h0);
    refresh_cycle <= 1'h0;
    {shift_clock_req, transfer_req} <= 2'h3;
    repeat (2) @(posedge aclk);
    check("bank soe", soes, 4'hb);
    check("bank sclk", shift_clock_bank_n, 4'hb);
    check("xfer oe", transfer_output_enable_n, 1'h0);
    pointer_fetch <= 1'h1;
    repeat (3) @(posedge aclk);
    check("ptr hi", pointer_addr_hi, 2'h1);
    check("ptr rows", rows, 4'hd);
    wr(`OFF_BUS_WIDTH_CTRL, 8'h40);
    repeat (2) @(posedge aclk);
    check("flat rows", rows, 4'h0);
    check("flat soe sclk", {soes, shift_clock_bank_n}, 8'h00);
    check("extra row", {extra_row_address, pointer_addr_hi}, 3'h6);
    {pointer_fetch, row_strobe_req, shift_clock_req, transfer_req} <= 4'h0;
  endtask
  task automatic t_cpu;
    int cw, rn, fw, rp, rf, rw;
    wr(`OFF_BUS_WIDTH_CTRL, 8'h00);
    cpu(1'h1, 18'h10, 16'h005a, cw);
    cpu(1'h0, 18'h10, 16'h0, rn);
    check("slow rd", cpu_rdata[7:0], 8'h5a);
    wr(`OFF_BUS_WIDTH_CTRL, 8'h04);
    cpu(1'h1, 18'h12, 16'h00c3, fw);
    cpu(1'h0, 18'h12, 16'h0, rp);
    check("posted rd", cpu_rdata[7:0], 8'hc3);
    cpu(1'h0, 18'h10, 16'h0, rf);
    check("post faster", fw < cw, 1'h1);
    check("wait on pending", rp > rf, 1'h1);
    check("read same", rf, rn);
    wr(`OFF_BUS_WIDTH_CTRL, 8'h05);
    high_byte_enable_input_n <= 1'h0;
    cpu(1'h0, 18'h10, 16'h0, rw);
    check("wide extra", rw - rn, 4);
    check("wide rd", cpu_rdata, 16'hee5a);
  endtask
  initial begin
    n_fail = 0;
    samples_checked = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {cpu_mem_req, cpu_mem_write, cpu_io_req, pointer_fetch, refresh_cycle, row_strobe_req} = 6'h0;
    {shift_clock_req, transfer_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 54'h0;
    {cpu_addr, cpu_wdata} = 34'h0;
    {bus16_present, high_byte_enable_input_n, rom_decode_input_n} = 3'h7;
    s_axi_wstrb = 4'h1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_lock;
    t_ctrl;
    t_rom;
    t_io;
    t_bank;
    t_cpu;
    end_of_test;
  end
endmodule // test_host_bus_width_control
